/* logic/dac_map.svh */
// register map offsets, field positions, reset values and masks
`ifndef DAC_MAP_SVH
`define DAC_MAP_SVH

// ==========================================
// offsets
`define DAC_A_SERCFG   5'h00
`define DAC_A_INTERP   5'h01
`define DAC_A_DPATH    5'h02
`define DAC_A_ICTL     5'h0c
`define DAC_A_AUX1LO   5'h0d
`define DAC_A_AUX1CTL  5'h0e
`define DAC_A_QGAINLO  5'h0f
`define DAC_A_QCTL     5'h10
`define DAC_A_AUX2LO   5'h11
`define DAC_A_AUX2CTL  5'h12
`define DAC_A_FLAGS    5'h19
`define DAC_A_VERSION  5'h1f

// ==========================================
// field positions
`define DAC_B_BIDIR    7
`define DAC_B_LSBF     6
`define DAC_B_SRST     5
`define DAC_B_PD       4
`define DAC_B_LOCK     1
`define DAC_B_DERR     7
`define DAC_B_SERR     6
`define DAC_B_DTYPE    4
`define DAC_B_DEN      3
`define DAC_B_SEN      2

// ==========================================
// reset values and write masks
`define DAC_RST_ZERO   8'h00
`define DAC_RST_CTL    8'h01
`define DAC_RST_QGAIN  8'hf9
`define DAC_WM_SERCFG  8'hf8
`define DAC_WM_ALL     8'hff
`define DAC_WM_CTL     8'hc3
`define DAC_WM_AUXCTL  8'he3
`define DAC_WM_FLAGS   8'h0d
`define DAC_WM_NONE    8'h00

`endif

/* logic/dac_pkg.sv */
// types shared by the register bank and its helpers
package dac_pkg;

  // ==========================================
  // serial port states
  typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA} dac_state_t;

  // ==========================================
  // global configuration
  typedef struct packed {
    logic       bidir;
    logic       lsb_first;
    logic       soft_reset;
    logic       power_down;
    logic       auto_pd;
    logic [1:0] interp;
    logic [3:0] filt_mode;
    logic       dclk_dly_msb;
    logic       zero_stuff;
    logic       data_format;
    logic       single_port;
    logic       real_mode;
    logic       dclk_dly_en;
    logic       inv_sinc;
    logic       dclk_invert;
    logic       txen_invert;
    logic       q_first;
  } dac_cfg_t;

  // ==========================================
  // per converter channel and per auxiliary dac
  typedef struct packed {
    logic       sleep;
    logic       pd;
    logic [1:0] gain_hi;
  } dac_chan_t;

  typedef struct packed {
    logic       sign;
    logic       dir;
    logic       pd;
    logic [9:0] value;
  } dac_aux_t;

endpackage : dac_pkg

/* logic/dac_sync.sv */
// two flip-flop synchronisers, one per bit
`timescale 1ns/1ns
module dac_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  // levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  // ==========================================
  // stages
  for (genvar g = 0; g < W; g++) begin : g_bit
    logic meta_ff;
    logic sync_ff;
    logic nxt_meta;
    logic nxt_sync;
    always_comb begin
      nxt_meta = async_i[g];
      nxt_sync = meta_ff;
    end
    always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
        meta_ff <= RST_VAL[g];
        sync_ff <= RST_VAL[g];
      end else begin
        meta_ff <= nxt_meta;
        sync_ff <= nxt_sync;
      end
    end
    assign sync_o[g] = sync_ff;
  end
endmodule : dac_sync

/* logic/dac_shift.sv */
// serial byte shifter, either bit order
`timescale 1ns/1ns
module dac_shift (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  // serial side
  input  wire logic       rise_i,
  input  wire logic       fall_i,
  input  wire logic       clr_i,
  input  wire logic       lsb_first_i,
  input  wire logic       din_i,
  // byte side
  input  wire logic       load_i,
  input  wire logic [7:0] load_byte_i,
  output logic            byte_done_o,
  output logic      [7:0] rx_byte_o,
  output logic            dout_o
);
  logic [2:0] cnt_ff;
  logic [7:0] rx_ff;
  logic [7:0] tx_ff;
  logic       dout_ff;
  logic       done_ff;
  logic [2:0] nxt_cnt;
  logic [7:0] nxt_rx;
  logic [7:0] nxt_tx;
  logic       nxt_dout;
  logic       nxt_done;

  // ==========================================
  // shift
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_rx   = rx_ff;
    nxt_tx   = tx_ff;
    nxt_done = 1'b0;
    if (clr_i) begin
      nxt_cnt = 3'h0;
    end else if (rise_i) begin
      nxt_rx   = lsb_first_i ? {din_i, rx_ff[7:1]} : {rx_ff[6:0], din_i};
      nxt_cnt  = cnt_ff + 3'h1;
      nxt_done = (cnt_ff == 3'h7);
    end
    // the first bit of a fresh byte is already on the pin at count zero
    if (load_i) begin
      nxt_tx = load_byte_i;
    end else if (fall_i && cnt_ff != 3'h0) begin
      nxt_tx = lsb_first_i ? {1'b0, tx_ff[7:1]} : {tx_ff[6:0], 1'b0};
    end
    nxt_dout = lsb_first_i ? nxt_tx[0] : nxt_tx[7];
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cnt_ff  <= 3'h0;
      rx_ff   <= 8'h00;
      tx_ff   <= 8'h00;
      dout_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      rx_ff   <= nxt_rx;
      tx_ff   <= nxt_tx;
      dout_ff <= nxt_dout;
      done_ff <= nxt_done;
    end
  end

  assign byte_done_o = done_ff;
  assign rx_byte_o   = rx_ff;
  assign dout_o      = dout_ff;
endmodule : dac_shift

/* logic/dac_regbank.sv */
// control register bank of a dual dac behind a three-wire serial port
// ==========================================
`timescale 1ns/1ns
`include "dac_map.svh"
module dac_regbank #(
  parameter logic [7:0] VERSION_ID = 8'h5a // arbitrary value
) (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  // three-wire serial port
  input  wire logic              sclk_i,
  input  wire logic              cs_n_i,
  input  wire logic              sdio_i,
  output logic                   sdio_o,
  output logic                   sdio_oe_o,
  output logic                   sdo_o,
  output logic                   sdo_oe_o,
  // status inputs
  input  wire logic              pll_locked_i,
  input  wire logic              txen_pin_i,
  input  wire logic              data_err_i,
  input  wire logic              data_err_type_i,
  input  wire logic              sync_err_i,
  // configuration outputs
  output dac_pkg::dac_cfg_t      cfg_o,
  output dac_pkg::dac_chan_t     i_chan_o,
  output dac_pkg::dac_chan_t     q_chan_o,
  output logic             [7:0] q_gain_lo_o,
  output dac_pkg::dac_aux_t      aux1_o,
  output dac_pkg::dac_aux_t      aux2_o,
  output logic                   loopback_o,
  // datapath enables
  output logic                   core_en_o,
  output logic                   port2_en_o,
  output logic                   q_path_en_o,
  output logic                   tx_enable_o
);
  // ==========================================
  // pin synchronisers
  logic [4:0] pins_s;
  logic       sclk_s;
  logic       cs_n_s;
  logic       sdio_s;
  logic       lock_s;
  logic       txen_s;

  dac_sync #(
    .W       (5),
    .RST_VAL (5'h02)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({txen_pin_i, pll_locked_i, sdio_i, cs_n_i, sclk_i}),
    .sync_o    (pins_s)
  );

  assign sclk_s = pins_s[0];
  assign cs_n_s = pins_s[1];
  assign sdio_s = pins_s[2];
  assign lock_s = pins_s[3];
  assign txen_s = pins_s[4];

  // ==========================================
  // clock edge detect
  logic sclk_d_ff;
  logic nxt_sclk_d;
  logic rise;
  logic fall;

  always_comb begin
    nxt_sclk_d = sclk_s;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sclk_d_ff <= 1'b0;
    end else begin
      sclk_d_ff <= nxt_sclk_d;
    end
  end

  assign rise = sclk_s & ~sclk_d_ff & ~cs_n_s;
  assign fall = ~sclk_s & sclk_d_ff & ~cs_n_s;

  // ==========================================
  // register storage
  logic [7:0] regs_ff [32];
  logic [7:0] nxt_regs [32];

  function automatic logic [7:0] rst_val(input logic [4:0] a);
    logic [7:0] v;
    v = `DAC_RST_ZERO;
    if (a == `DAC_A_ICTL || a == `DAC_A_QCTL) begin
      v = `DAC_RST_CTL;
    end else if (a == `DAC_A_QGAINLO) begin
      v = `DAC_RST_QGAIN;
    end
    return v;
  endfunction : rst_val

  // lock bit and the flag bits are outside the writable mask
  function automatic logic [7:0] wmask(input logic [4:0] a);
    logic [7:0] m;
    unique case (a)
      `DAC_A_SERCFG:                    m = `DAC_WM_SERCFG;
      `DAC_A_INTERP, `DAC_A_DPATH:      m = `DAC_WM_ALL;
      `DAC_A_AUX1LO, `DAC_A_QGAINLO:    m = `DAC_WM_ALL;
      `DAC_A_AUX2LO:                    m = `DAC_WM_ALL;
      `DAC_A_ICTL, `DAC_A_QCTL:         m = `DAC_WM_CTL;
      `DAC_A_AUX1CTL, `DAC_A_AUX2CTL:   m = `DAC_WM_AUXCTL;
      `DAC_A_FLAGS:                     m = `DAC_WM_FLAGS;
      default:                          m = `DAC_WM_NONE;
    endcase
    return m;
  endfunction : wmask

  // ==========================================
  // serial protocol state
  dac_pkg::dac_state_t state_ff;
  dac_pkg::dac_state_t nxt_state;
  logic [4:0] addr_ff;
  logic [4:0] nxt_addr;
  logic       rd_ff;
  logic       nxt_rd;
  logic       byte_done;
  logic [7:0] rx_byte;
  logic       dout;
  logic       load;
  logic [7:0] load_byte;
  logic       wr_stb;
  logic [4:0] step_addr;

  function automatic logic [7:0] rd_val(input logic [4:0] a);
    logic [7:0] v;
    v = regs_ff[a] & wmask(a);
    if (a == `DAC_A_SERCFG) begin
      v[`DAC_B_LOCK] = lock_s;
    end else if (a == `DAC_A_FLAGS) begin
      v = regs_ff[a];
    end else if (a == `DAC_A_VERSION) begin
      v = VERSION_ID;
    end
    return v;
  endfunction : rd_val

  dac_shift u_shift (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .rise_i      (rise),
    .fall_i      (fall),
    .clr_i       (cs_n_s),
    .lsb_first_i (regs_ff[`DAC_A_SERCFG][`DAC_B_LSBF]),
    .din_i       (sdio_s),
    .load_i      (load),
    .load_byte_i (load_byte),
    .byte_done_o (byte_done),
    .rx_byte_o   (rx_byte),
    .dout_o      (dout)
  );

  // address walks down in msb-first order, up in lsb-first
  assign step_addr = regs_ff[`DAC_A_SERCFG][`DAC_B_LSBF] ? addr_ff + 5'h01
                                                          : addr_ff - 5'h01;

  always_comb begin
    nxt_state = state_ff;
    nxt_addr  = addr_ff;
    nxt_rd    = rd_ff;
    load      = 1'b0;
    load_byte = 8'h00;
    wr_stb    = 1'b0;
    if (cs_n_s) begin
      nxt_state = dac_pkg::ST_IDLE;
    end else begin
      unique case (state_ff)
        dac_pkg::ST_IDLE: begin
          nxt_state = dac_pkg::ST_INSTR;
        end
        dac_pkg::ST_INSTR: begin
          if (byte_done) begin
            nxt_state = dac_pkg::ST_DATA;
            nxt_rd    = rx_byte[7];
            nxt_addr  = rx_byte[4:0];
            load      = rx_byte[7];
            load_byte = rd_val(rx_byte[4:0]);
          end
        end
        dac_pkg::ST_DATA: begin
          if (byte_done) begin
            wr_stb    = ~rd_ff;
            nxt_addr  = step_addr;
            load      = rd_ff;
            load_byte = rd_val(step_addr);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_ff <= dac_pkg::ST_IDLE;
      addr_ff  <= 5'h00;
      rd_ff    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      addr_ff  <= nxt_addr;
      rd_ff    <= nxt_rd;
    end
  end

  // ==========================================
  // register updates
  logic [7:0] flags;
  logic       derr_set;
  logic       serr_set;

  assign flags    = regs_ff[`DAC_A_FLAGS];
  assign derr_set = data_err_i & flags[`DAC_B_DEN];
  assign serr_set = sync_err_i & flags[`DAC_B_SEN];

  always_comb begin
    for (int a = 0; a < 32; a++) begin
      nxt_regs[a] = regs_ff[a];
    end
    if (wr_stb) begin
      nxt_regs[addr_ff] = (regs_ff[addr_ff] & ~wmask(addr_ff)) | (rx_byte & wmask(addr_ff));
      if (addr_ff == `DAC_A_FLAGS) begin
        nxt_regs[addr_ff][`DAC_B_DERR] = flags[`DAC_B_DERR] & ~rx_byte[`DAC_B_DERR];
        nxt_regs[addr_ff][`DAC_B_SERR] = flags[`DAC_B_SERR] & ~rx_byte[`DAC_B_SERR];
      end
    end
    // map above address 0 held at defaults while the reset bit stays high
    if (regs_ff[`DAC_A_SERCFG][`DAC_B_SRST]) begin
      for (int a = 1; a < 32; a++) begin
        nxt_regs[a] = rst_val(5'(a));
      end
    end
    // a flag event wins over a clear in the same cycle
    if (derr_set) begin
      nxt_regs[`DAC_A_FLAGS][`DAC_B_DERR]  = 1'b1;
      nxt_regs[`DAC_A_FLAGS][`DAC_B_DTYPE] = data_err_type_i;
    end
    if (serr_set) begin
      nxt_regs[`DAC_A_FLAGS][`DAC_B_SERR] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    for (int a = 0; a < 32; a++) begin
      if (sys_rst_i) begin
        regs_ff[a] <= rst_val(5'(a));
      end else begin
        regs_ff[a] <= nxt_regs[a];
      end
    end
  end

  // ==========================================
  // serial data out
  logic reading;
  logic bidir;

  assign bidir     = regs_ff[`DAC_A_SERCFG][`DAC_B_BIDIR];
  assign reading   = (state_ff == dac_pkg::ST_DATA) & rd_ff & ~cs_n_s;
  assign sdio_o    = dout;
  assign sdio_oe_o = reading & bidir;
  assign sdo_o     = dout;
  assign sdo_oe_o  = reading & ~bidir;

  // ==========================================
  // configuration fields
  logic [7:0] r0;
  logic [7:0] r1;
  logic [7:0] r2;

  assign r0 = regs_ff[`DAC_A_SERCFG];
  assign r1 = regs_ff[`DAC_A_INTERP];
  assign r2 = regs_ff[`DAC_A_DPATH];

  always_comb begin
    cfg_o.bidir        = r0[7];
    cfg_o.lsb_first    = r0[6];
    cfg_o.soft_reset   = r0[5];
    cfg_o.power_down   = r0[4];
    cfg_o.auto_pd      = r0[3];
    cfg_o.interp       = r1[7:6];
    cfg_o.filt_mode    = r1[5:2];
    cfg_o.dclk_dly_msb = r1[1];
    cfg_o.zero_stuff   = r1[0] & core_en_o;
    cfg_o.data_format  = r2[7];
    cfg_o.single_port  = r2[6];
    cfg_o.real_mode    = r2[5];
    cfg_o.dclk_dly_en  = r2[4];
    cfg_o.inv_sinc     = r2[3] & core_en_o;
    cfg_o.dclk_invert  = r2[2];
    cfg_o.txen_invert  = r2[1];
    cfg_o.q_first      = r2[0];
  end

  assign i_chan_o    = {regs_ff[`DAC_A_ICTL][7:6], regs_ff[`DAC_A_ICTL][1:0]};
  assign q_chan_o    = {regs_ff[`DAC_A_QCTL][7:6], regs_ff[`DAC_A_QCTL][1:0]};
  assign q_gain_lo_o = regs_ff[`DAC_A_QGAINLO];
  assign aux1_o      = {regs_ff[`DAC_A_AUX1CTL][7:5], regs_ff[`DAC_A_AUX1CTL][1:0],
                        regs_ff[`DAC_A_AUX1LO]};
  assign aux2_o      = {regs_ff[`DAC_A_AUX2CTL][7:5], regs_ff[`DAC_A_AUX2CTL][1:0],
                        regs_ff[`DAC_A_AUX2LO]};
  assign loopback_o  = flags[0];

  // ==========================================
  // datapath enables
  assign core_en_o   = ~r0[`DAC_B_PD];
  assign port2_en_o  = core_en_o & ~r2[6];
  assign q_path_en_o = core_en_o & ~r2[5];
  assign tx_enable_o = core_en_o & (txen_s ^ r2[1]);
endmodule : dac_regbank

/* verif/dac_regbank_properties.sv */
// port assertions of the dac register bank
`timescale 1ns/1ns
module dac_regbank_properties (
  // clock and reset
  input wire logic              clk_sys_i,
  input wire logic              sys_rst_i,
  // pins and outputs watched
  input wire logic              cs_n_i,
  input wire logic              txen_pin_i,
  input wire logic              sdio_oe_o,
  input wire logic              sdo_oe_o,
  input wire dac_pkg::dac_cfg_t cfg_o,
  input wire logic        [7:0] q_gain_lo_o,
  input wire logic              core_en_o,
  input wire logic              port2_en_o,
  input wire logic              q_path_en_o,
  input wire logic              tx_enable_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // ==========
  // sequences
  // pin quiet long enough to clear the synchroniser
  sequence s_pin_quiet;
    ($stable(txen_pin_i) && $stable(cfg_o.txen_invert) && core_en_o)[*5];
  endsequence
  sequence s_srst_held;
    cfg_o.soft_reset ##1 cfg_o.soft_reset;
  endsequence
  // ==========
  // checks
  chk_core_en_pd: assert property (core_en_o == !cfg_o.power_down)
    else $error("core enable does not follow power-down");
  chk_port2_single: assert property (port2_en_o == (core_en_o && !cfg_o.single_port))
    else $error("second port enable wrong");
  chk_q_path_real: assert property (q_path_en_o == (core_en_o && !cfg_o.real_mode))
    else $error("q path enable wrong");
  chk_sdio_bidir: assert property (sdio_oe_o |-> cfg_o.bidir)
    else $error("data pin driven without bidir");
  chk_sdo_plain: assert property (sdo_oe_o |-> !cfg_o.bidir)
    else $error("out pin driven in bidir mode");
  chk_idle_quiet: assert property (cs_n_i [*6] |-> !(sdio_oe_o || sdo_oe_o))
    else $error("pin driven while deselected");
  chk_tx_follow: assert property (s_pin_quiet |-> tx_enable_o == (txen_pin_i ^ cfg_o.txen_invert))
    else $error("transmit enable polarity wrong");
  chk_srst_clear: assert property (s_srst_held |-> cfg_o.interp == 2'h0 &&
    cfg_o.filt_mode == 4'h0 && q_gain_lo_o == 8'hf9)
    else $error("soft reset left registers set");
endmodule : dac_regbank_properties

bind dac_regbank dac_regbank_properties i_props (.clk_sys_i, .sys_rst_i, .cs_n_i,
  .txen_pin_i, .sdio_oe_o, .sdo_oe_o, .cfg_o, .q_gain_lo_o, .core_en_o, .port2_en_o,
  .q_path_en_o, .tx_enable_o);

/* verif/dac_host_model.sv */
// host model driving the three-wire serial port
`timescale 1ns/1ns
module dac_host_model (
  // clock
  input  wire logic clk_sys_i,
  // device answers
  input  wire logic dev_sdio_i,
  input  wire logic dev_sdio_oe_i,
  input  wire logic dev_sdo_i,
  input  wire logic dev_sdo_oe_i,
  // serial pins
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdata_o
);
  logic lvl;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdata_o = 1'b0;
    lvl = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  // ==========
  // one byte; 6 clock phases keep clear of the 4 clock minimum
  task automatic shift(input logic [7:0] tx, input logic lsbf, input logic rd,
                       input logic bidir, output logic [7:0] rx);
    for (int i = 0; i < 8; i++) begin
      sclk_o = 1'b0;
      sdata_o = rd ? ~sdata_o : tx[lsbf ? i : 7 - i];
      tick(6);
      // a released line shows the inverse of its last level
      lvl = bidir ? (dev_sdio_oe_i ? dev_sdio_i : ~lvl) : (dev_sdo_oe_i ? dev_sdo_i : ~lvl);
      rx[lsbf ? i : 7 - i] = lvl;
      sclk_o = 1'b1;
      tick(6);
    end
  endtask : shift
  // ==========
  // instruction then n data bytes
  task automatic access(input logic rd, input logic [4:0] addr, input logic lsbf,
                        input logic bidir, input int n, input logic [15:0] wd,
                        output logic [15:0] rdat);
    logic [7:0] rx;
    rdat = 16'h0000;
    cs_n_o = 1'b0;
    tick(4);
    shift({rd, 2'b00, addr}, lsbf, 1'b0, bidir, rx);
    for (int k = 0; k < n; k++) begin
      shift(wd[8*k +: 8], lsbf, rd, bidir, rx);
      rdat[8*k +: 8] = rx;
    end
    sclk_o = 1'b0;
    tick(6);
    cs_n_o = 1'b1;
    tick(8);
  endtask : access
endmodule : dac_host_model

/* verif/dac_regbank_bench.sv */
// self-checking bench of the dac register bank
`timescale 1ns/1ns
module dac_regbank_bench;
  localparam logic [7:0] VER = 8'h3c; // arbitrary value
  logic               clk_sys_i, sys_rst_i, sclk_i, cs_n_i, sdio_i, host_dat;
  logic               sdio_o, sdio_oe_o, sdo_o, sdo_oe_o, pll_locked_i, txen_pin_i;
  logic               data_err_i, data_err_type_i, sync_err_i, loopback_o, lsbf, bidir;
  logic               core_en_o, port2_en_o, q_path_en_o, tx_enable_o;
  dac_pkg::dac_cfg_t  cfg_o;
  dac_pkg::dac_chan_t i_chan_o, q_chan_o;
  dac_pkg::dac_aux_t  aux1_o, aux2_o;
  logic         [7:0] q_gain_lo_o, d, e, exp_m [32];
  logic         [4:0] a;
  logic        [15:0] r;
  int                 error_cnt, check_count;
  assign sdio_i = sdio_oe_o ? sdio_o : host_dat;
  dac_regbank #(.VERSION_ID(VER)) i_dut (
    .clk_sys_i, .sys_rst_i, .sclk_i, .cs_n_i, .sdio_i, .sdio_o, .sdio_oe_o, .sdo_o,
    .sdo_oe_o, .pll_locked_i, .txen_pin_i, .data_err_i, .data_err_type_i, .sync_err_i,
    .cfg_o, .i_chan_o, .q_chan_o, .q_gain_lo_o, .aux1_o, .aux2_o, .loopback_o,
    .core_en_o, .port2_en_o, .q_path_en_o, .tx_enable_o);
  dac_host_model i_host (.clk_sys_i, .sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdata_o(host_dat),
    .dev_sdio_i(sdio_o), .dev_sdio_oe_i(sdio_oe_o), .dev_sdo_i(sdo_o), .dev_sdo_oe_i(sdo_oe_o));
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // ==========
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic xfer(input logic rd, input logic [4:0] ad, input int n, input logic [15:0] wd);
    i_host.access(rd, ad, lsbf, bidir, n, wd, r);
  endtask : xfer
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] wmask(input logic [4:0] ad);
    case (ad)
      5'h00: return 8'hf8;
      5'h01, 5'h02, 5'h0d, 5'h0f, 5'h11: return 8'hff;
      5'h0c, 5'h10: return 8'hc3;
      5'h0e, 5'h12: return 8'he3;
      5'h19: return 8'h0d;
      default: return 8'h00;
    endcase
  endfunction : wmask
  function automatic logic [7:0] dflt(input logic [4:0] ad);
    case (ad)
      5'h0c, 5'h10: return 8'h01;
      5'h0f: return 8'hf9;
      5'h1f: return VER;
      default: return 8'h00;
    endcase
  endfunction : dflt
  // lock input held high, so bit 1 of the first register reads one
  task automatic check_defaults;
    for (int i = 0; i < 32; i++) begin
      exp_m[i] = dflt(5'(i));
      xfer(1'b1, 5'(i), 1, 16'h0000);
      check(r, {8'h00, exp_m[i] | (i == 0 ? 8'h02 : 8'h00)});
    end
  endtask : check_defaults
  task automatic complete_run;
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    error_cnt++;
    complete_run();
  end
  // ==========
  // main sequence
  initial begin
    {sys_rst_i, pll_locked_i, txen_pin_i, data_err_i, data_err_type_i, sync_err_i} = 6'h30;
    {lsbf, bidir, error_cnt, check_count} = '0;
    void'($urandom(59));
    tick(3);
    sys_rst_i = 1'b0;
    tick(4);
    check_defaults();
    // random writes; unmapped places get unmasked data
    for (int i = 0; i < 40; i++) begin
      a = 5'($urandom);
      if (a == 5'h00) a = 5'h01;
      e = 8'($urandom);
      d = (wmask(a) == 8'h00) ? e : e & wmask(a);
      xfer(1'b0, a, 1, {8'h00, d});
      if (wmask(a) != 8'h00) exp_m[a] = d;
      if (a == 5'h01) check({cfg_o.interp, cfg_o.filt_mode, cfg_o.dclk_dly_msb, cfg_o.zero_stuff}, d);
      if (a == 5'h02) check({cfg_o.data_format, cfg_o.single_port, cfg_o.real_mode, cfg_o.dclk_dly_en,
        cfg_o.inv_sinc, cfg_o.dclk_invert, cfg_o.txen_invert, cfg_o.q_first}, d);
      if (a == 5'h0c) check(i_chan_o, {d[7:6], d[1:0]});
      if (a == 5'h10) check(q_chan_o, {d[7:6], d[1:0]});
      if (a == 5'h0f) check(q_gain_lo_o, d);
      if (a == 5'h19) check(loopback_o, d[0]);
    end
    for (int i = 1; i < 32; i++) begin
      xfer(1'b1, 5'(i), 1, 16'h0000);
      check(r, {8'h00, exp_m[i]});
    end
    // enabled error events latch; a one clears them, the type bit stays
    xfer(1'b0, 5'h19, 1, 16'h000c);
    {data_err_i, data_err_type_i, sync_err_i} = 3'h7;
    tick(1);
    {data_err_i, data_err_type_i, sync_err_i} = 3'h0;
    xfer(1'b1, 5'h19, 1, 16'h0000);
    check(r, 16'h00dc);
    xfer(1'b0, 5'h19, 1, 16'h00cc);
    xfer(1'b1, 5'h19, 1, 16'h0000);
    check(r, 16'h001c);
    pll_locked_i = 1'b0;
    xfer(1'b0, 5'h00, 1, 16'h0007);
    xfer(1'b1, 5'h00, 1, 16'h0000);
    check(r, 16'h0000);
    xfer(1'b0, 5'h00, 1, 16'h0080);
    bidir = 1'b1;
    xfer(1'b1, 5'h0f, 1, 16'h0000);
    check(r, {8'h00, exp_m[15]});
    xfer(1'b0, 5'h00, 1, 16'h0000);
    bidir = 1'b0;
    // two-byte access steps down, then up after order change
    d = 8'($urandom);
    e = 8'($urandom) & 8'he3;
    xfer(1'b0, 5'h0e, 2, {d, e});
    check(aux1_o, {e[7:5], e[1:0], d});
    xfer(1'b1, 5'h0e, 2, 16'h0000);
    check(r, {d, e});
    xfer(1'b0, 5'h00, 1, 16'h0040);
    lsbf = 1'b1;
    xfer(1'b0, 5'h11, 2, {e, d});
    check(aux2_o, {e[7:5], e[1:0], d});
    xfer(1'b1, 5'h1f, 2, 16'h0000);
    check(r, {8'h40, VER});
    xfer(1'b0, 5'h00, 1, 16'h0000);
    lsbf = 1'b0;
    xfer(1'b0, 5'h00, 1, 16'h0010);
    check({core_en_o, port2_en_o, q_path_en_o, tx_enable_o}, 16'h0000);
    xfer(1'b1, 5'h0f, 1, 16'h0000);
    check(r, {8'h00, exp_m[15]});
    xfer(1'b0, 5'h00, 1, 16'h0000);
    check(core_en_o, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 5'h02, 1, {14'h0000, i[0], 1'b0});
      txen_pin_i = 1'($urandom);
      tick(5);
      check(tx_enable_o, txen_pin_i ^ i[0]);
    end
    pll_locked_i = 1'b1;
    xfer(1'b0, 5'h00, 1, 16'h0020);
    xfer(1'b0, 5'h00, 1, 16'h0000);
    check_defaults();
    complete_run();
  end
endmodule : dac_regbank_bench
